// *** iep_master.sv ***
// Bus master end: polling, byte write, current and random sequential reads.
`timescale 1ns/1ns
`include "iep_params.svh"
module iep_master (
  input  wire logic  mclk,
  input  wire logic  arst_n,
  iep_if.master      bus,
  input  wire logic  req_valid,
  output logic       req_ready,
  input  wire logic [1:0] req_op,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  input  wire logic [7:0] req_len,
  output logic       rd_valid,
  output logic [7:0] rd_data,
  output logic       done,
  output logic       done_nack
);

  // **************************************************************
  // Data wire sampling and quarter-bit divider
  // **************************************************************
  logic [2:0]       sda_s_r, sda_s_nxt;
  logic             sda_f_r, sda_f_nxt;
  logic [7:0]       tick_r, tick_nxt;
  logic             tick;

  always_comb begin
    sda_s_nxt = {sda_s_r[1:0], bus.sda};
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    tick      = (tick_r == 8'(`IEP_QTR_CYC - 1));
    tick_nxt  = tick ? 8'h00 : tick_r + 8'h01;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_s_r <= 3'h7;
      sda_f_r <= 1'b1;
      tick_r  <= 8'h00;
    end else begin
      sda_s_r <= sda_s_nxt;
      sda_f_r <= sda_f_nxt;
      tick_r  <= tick_nxt;
    end
  end

  // **************************************************************
  // Transfer sequencer
  // **************************************************************
  iep_pkg::iep_mst_t st_r, st_nxt;
  iep_pkg::iep_seq_t seq_r, seq_nxt;
  iep_pkg::iep_op_t  op_r, op_nxt;
  logic [1:0]       ph_r, ph_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [7:0]       addr_r, addr_nxt;
  logic [7:0]       data_r, data_nxt;
  logic [7:0]       left_r, left_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic [7:0]       rx_r, rx_nxt;
  logic             scl_r, scl_nxt;
  logic             oe_r, oe_nxt;
  logic             nak_r, nak_nxt;
  logic             rdv_r, rdv_nxt;
  logic [7:0]       rdd_r, rdd_nxt;
  logic             dn_r, dn_nxt;
  logic             dnn_r, dnn_nxt;
  logic             tx;

  assign tx = (seq_r != iep_pkg::SQ_RD);

  // Each bit is four quarters: set data, raise clock, sample, drop clock.
  always_comb begin
    st_nxt   = st_r;
    seq_nxt  = seq_r;
    op_nxt   = op_r;
    ph_nxt   = ph_r;
    bit_nxt  = bit_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    left_nxt = left_r;
    sh_nxt   = sh_r;
    rx_nxt   = rx_r;
    scl_nxt  = scl_r;
    oe_nxt   = oe_r;
    nak_nxt  = nak_r;
    rdd_nxt  = rdd_r;
    dnn_nxt  = dnn_r;
    rdv_nxt  = 1'b0;
    dn_nxt   = 1'b0;
    if (tick && (st_r != iep_pkg::MS_IDLE)) begin
      ph_nxt = ph_r + 2'h1;
    end
    unique case (st_r)
      iep_pkg::MS_IDLE: begin
        if (req_valid) begin
          op_nxt   = iep_pkg::iep_op_t'(req_op);
          addr_nxt = req_addr;
          data_nxt = req_data;
          left_nxt = (req_len == 8'h00) ? 8'h01 : req_len;
          nak_nxt  = 1'b0;
          ph_nxt   = 2'h0;
          st_nxt   = iep_pkg::MS_START;
          // A current read opens with the read direction, all else writes.
          seq_nxt  = (req_op == iep_pkg::OP_READ_CUR) ? iep_pkg::SQ_DEVR :
                     iep_pkg::SQ_DEVW;
        end
      end
      iep_pkg::MS_START: begin
        if (tick) begin
          unique case (ph_r)
            2'h0: begin
              scl_nxt = 1'b0;
              oe_nxt  = 1'b0;
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b1;             // Data falls with clock high.
            2'h3: begin
              scl_nxt = 1'b0;
              bit_nxt = 4'h0;
              sh_nxt  = {`IEP_DEV_ADDR, (seq_r == iep_pkg::SQ_DEVR)};
              st_nxt  = iep_pkg::MS_BYTE;
            end
          endcase
        end
      end
      iep_pkg::MS_BYTE: begin
        if (tick) begin
          unique case (ph_r)
            2'h0: begin
              scl_nxt = 1'b0;
              if (bit_r < `IEP_ACK_BIT) begin
                oe_nxt = tx & ~sh_r[7];
              end else begin
                oe_nxt = ~tx & (left_r > 8'h01);
              end
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: begin
              if (bit_r == `IEP_ACK_BIT) begin
                nak_nxt = tx & sda_f_r;
              end else if (!tx) begin
                rx_nxt = {rx_r[6:0], sda_f_r};
              end
            end
            2'h3: begin
              scl_nxt = 1'b0;
              if (bit_r < `IEP_ACK_BIT) begin
                bit_nxt = bit_r + 4'h1;
                sh_nxt  = {sh_r[6:0], 1'b0};
              end else begin
                bit_nxt = 4'h0;
                if (nak_r) begin
                  st_nxt = iep_pkg::MS_STOP; // Refused byte: give up now.
                end else begin
                  unique case (seq_r)
                    iep_pkg::SQ_DEVW: begin
                      if (op_r == iep_pkg::OP_POLL) begin
                        st_nxt = iep_pkg::MS_STOP;
                      end else begin
                        seq_nxt = iep_pkg::SQ_ADDR;
                        sh_nxt  = addr_r;
                      end
                    end
                    iep_pkg::SQ_ADDR: begin
                      if (op_r == iep_pkg::OP_WRITE) begin
                        seq_nxt = iep_pkg::SQ_DATA;
                        sh_nxt  = data_r;
                      end else begin
                        seq_nxt = iep_pkg::SQ_DEVR;
                        st_nxt  = iep_pkg::MS_START;
                      end
                    end
                    iep_pkg::SQ_DATA: st_nxt = iep_pkg::MS_STOP;
                    iep_pkg::SQ_DEVR: seq_nxt = iep_pkg::SQ_RD;
                    iep_pkg::SQ_RD: begin
                      rdv_nxt = 1'b1;
                      rdd_nxt = rx_r;
                      if (left_r > 8'h01) begin
                        left_nxt = left_r - 8'h01;
                      end else begin
                        st_nxt = iep_pkg::MS_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      iep_pkg::MS_STOP: begin
        if (tick) begin
          unique case (ph_r)
            2'h0: begin
              scl_nxt = 1'b0;
              oe_nxt  = 1'b1;
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b0;             // Data rises with clock high.
            2'h3: begin
              dn_nxt  = 1'b1;
              dnn_nxt = nak_r;
              st_nxt  = iep_pkg::MS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= iep_pkg::MS_IDLE;
      seq_r  <= iep_pkg::SQ_DEVW;
      op_r   <= iep_pkg::OP_POLL;
      ph_r   <= 2'h0;
      bit_r  <= 4'h0;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      left_r <= 8'h00;
      sh_r   <= 8'h00;
      rx_r   <= 8'h00;
      scl_r  <= 1'b1;
      oe_r   <= 1'b0;
      nak_r  <= 1'b0;
      rdv_r  <= 1'b0;
      rdd_r  <= 8'h00;
      dn_r   <= 1'b0;
      dnn_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      seq_r  <= seq_nxt;
      op_r   <= op_nxt;
      ph_r   <= ph_nxt;
      bit_r  <= bit_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      left_r <= left_nxt;
      sh_r   <= sh_nxt;
      rx_r   <= rx_nxt;
      scl_r  <= scl_nxt;
      oe_r   <= oe_nxt;
      nak_r  <= nak_nxt;
      rdv_r  <= rdv_nxt;
      rdd_r  <= rdd_nxt;
      dn_r   <= dn_nxt;
      dnn_r  <= dnn_nxt;
    end
  end

  assign bus.scl      = scl_r;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = oe_r;
  assign req_ready    = (st_r == iep_pkg::MS_IDLE);
  assign rd_valid     = rdv_r;
  assign rd_data      = rdd_r;
  assign done         = dn_r;
  assign done_nack    = dnn_r;

endmodule

// *** iep_params.svh ***
// Timing, address and reset constants shared by both ends of the EEPROM link.
`ifndef IEP_PARAMS_SVH
`define IEP_PARAMS_SVH
`define IEP_MCLK_NS   8
`define IEP_SCL_NS    1280
`define IEP_QTR_CYC   (`IEP_SCL_NS / 4 / `IEP_MCLK_NS)
`define IEP_TWR_NS    5000000
`define IEP_TWR_CYC   (`IEP_TWR_NS / `IEP_MCLK_NS)
`define IEP_DEV_ADDR  7'h50
`define IEP_MEM_DEPTH 256
`define IEP_ACK_BIT   4'h8
`define IEP_ERASED    8'hFF
`endif

// *** iep_pkg.sv ***
// Types shared by the EEPROM slave and the bus master.
package iep_pkg;
  typedef enum logic [8:0] {
    SS_IDLE   = 9'h001,
    SS_DEV    = 9'h002,
    SS_DEVACK = 9'h004,
    SS_WORD   = 9'h008,
    SS_WACK   = 9'h010,
    SS_DATA   = 9'h020,
    SS_DACK   = 9'h040,
    SS_TX     = 9'h080,
    SS_TACK   = 9'h100
  } iep_sst_t;
  typedef enum logic [3:0] {
    MS_IDLE  = 4'h1,
    MS_START = 4'h2,
    MS_BYTE  = 4'h4,
    MS_STOP  = 4'h8
  } iep_mst_t;
  typedef enum logic [4:0] {
    SQ_DEVW = 5'h01,
    SQ_ADDR = 5'h02,
    SQ_DATA = 5'h04,
    SQ_DEVR = 5'h08,
    SQ_RD   = 5'h10
  } iep_seq_t;
  typedef enum logic [1:0] {
    OP_POLL      = 2'h0,
    OP_WRITE     = 2'h1,
    OP_READ_CUR  = 2'h2,
    OP_READ_RAND = 2'h3
  } iep_op_t;
endpackage

// *** iep_if.sv ***
// Two-wire link between the bus master and the EEPROM slave.
`timescale 1ns/1ns
interface iep_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // The data wire is pulled up; any end that drives a zero pulls it low.
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface

// *** iep_slave.sv ***
// EEPROM slave end: polling, write protection and the three read modes.
`timescale 1ns/1ns
`include "iep_params.svh"
// How it works
// - Internal write cycle starts at write STOP.
// - Master polls with START and write address.
// - Busy device leaves polling address unacknowledged.
// - Finished device acknowledges poll; transfers continue.
// - Write protect makes the array read only.
// - Protected: ack addresses, refuse first data byte.
// - Reads begin like writes, direction bit one.
// - Counter holds last accessed location plus one.
// - Counter wraps from top location to zero.
// - Current read: ack address, send counter byte.
// - Master ends single read with nack, STOP.
// - Random read starts with a dummy write.
// - Repeated START, read address, device returns byte.
// - Sequential read continues while master acknowledges.
// - Each master ack sends the next location.
// - Every counter bit increments during reads.
// - Receiver pulls data low on ninth clock.
// - Master nack: stop sending, release, await STOP.
// - Master sends word address after slave address.
module iep_slave #(
  parameter int unsigned TWR_CYC = `IEP_TWR_CYC
) (
  input  wire logic  mclk,
  input  wire logic  arst_n,
  iep_if.slave       bus,
  input  wire logic  wp,
  output logic       wr_busy
);

  // **************************************************************
  // Pin sampling
  // **************************************************************
  logic [2:0]       scl_s_r, scl_s_nxt;
  logic [2:0]       sda_s_r, sda_s_nxt;
  logic [2:0]       wp_s_r, wp_s_nxt;
  logic             scl_f_r, scl_f_nxt;
  logic             sda_f_r, sda_f_nxt;
  logic             wp_f_r, wp_f_nxt;
  logic             scl_q_r, sda_q_r;
  logic             rise, fall, start, stop;
  // A level counts only once the second and third stages agree, which
  // rejects a single-cycle glitch on the slow wires and the protect pin.
  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], bus.scl};
    sda_s_nxt = {sda_s_r[1:0], bus.sda};
    wp_s_nxt  = {wp_s_r[1:0], wp};
    scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    wp_f_nxt  = (wp_s_r[1] == wp_s_r[2]) ? wp_s_r[2] : wp_f_r;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      wp_s_r  <= 3'h0;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      wp_f_r  <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      wp_s_r  <= wp_s_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      wp_f_r  <= wp_f_nxt;
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end
  // Bus events from the filtered levels.
  assign rise  = scl_f_r & ~scl_q_r;
  assign fall  = ~scl_f_r & scl_q_r;
  assign start = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  assign stop  = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
  // **************************************************************
  // Protocol engine
  // **************************************************************
  iep_pkg::iep_sst_t st_r, st_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic [7:0]       tx_r, tx_nxt;
  logic [7:0]       ptr_r, ptr_nxt;
  logic             rw_r, rw_nxt;
  logic             oe_r, oe_nxt;
  logic             tack_r, tack_nxt;
  logic             pend_r, pend_nxt;
  logic [7:0]       pa_r, pa_nxt;
  logic [7:0]       pd_r, pd_nxt;
  logic [23:0]      busy_r, busy_nxt;
  logic             commit, load_tx, rx_st;
  logic [7:0]       mem_r [`IEP_MEM_DEPTH];
  logic [7:0]       mem_nxt [`IEP_MEM_DEPTH];
  assign rx_st = (st_r == iep_pkg::SS_DEV) || (st_r == iep_pkg::SS_WORD) ||
                 (st_r == iep_pkg::SS_DATA);
  // START and STOP are honoured in every state; bytes move on SCL edges.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    tx_nxt   = tx_r;
    ptr_nxt  = ptr_r;
    rw_nxt   = rw_r;
    oe_nxt   = oe_r;
    tack_nxt = tack_r;
    pend_nxt = pend_r;
    pa_nxt   = pa_r;
    pd_nxt   = pd_r;
    busy_nxt = (busy_r != 24'h0) ? busy_r - 24'h1 : busy_r;
    commit   = 1'b0;
    load_tx  = 1'b0;
    if (start) begin
      st_nxt  = iep_pkg::SS_DEV;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt = iep_pkg::SS_IDLE;
      oe_nxt = 1'b0;
      if (pend_r) begin
        commit   = 1'b1;
        pend_nxt = 1'b0;
        busy_nxt = 24'(TWR_CYC);
      end
    end else begin
      if (rx_st && rise && (cnt_r < `IEP_ACK_BIT)) begin
        sh_nxt  = {sh_r[6:0], sda_f_r};
        cnt_nxt = cnt_r + 4'h1;
      end
      unique case (st_r)
        iep_pkg::SS_IDLE: ;
        iep_pkg::SS_DEV: begin
          if (fall && (cnt_r == `IEP_ACK_BIT)) begin
            if ((sh_r[7:1] == `IEP_DEV_ADDR) && (busy_r == 24'h0)) begin
              oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
              st_nxt = iep_pkg::SS_DEVACK;
            end else begin
              st_nxt = iep_pkg::SS_IDLE;
            end
          end
        end
        iep_pkg::SS_DEVACK: begin
          if (fall) begin
            oe_nxt = 1'b0;
            if (rw_r) begin
              load_tx = 1'b1;
            end else begin
              cnt_nxt = 4'h0;
              st_nxt  = iep_pkg::SS_WORD;
            end
          end
        end
        iep_pkg::SS_WORD: begin
          if (fall && (cnt_r == `IEP_ACK_BIT)) begin
            ptr_nxt = sh_r;
            oe_nxt  = 1'b1;
            st_nxt  = iep_pkg::SS_WACK;
          end
        end
        iep_pkg::SS_WACK, iep_pkg::SS_DACK: begin
          if (fall) begin
            oe_nxt  = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt  = iep_pkg::SS_DATA;
          end
        end
        iep_pkg::SS_DATA: begin
          if (fall && (cnt_r == `IEP_ACK_BIT)) begin
            if (wp_f_r) begin
              st_nxt = iep_pkg::SS_IDLE;
            end else begin
              pend_nxt = 1'b1;
              pa_nxt   = ptr_r;
              pd_nxt   = sh_r;
              ptr_nxt  = ptr_r + 8'h1;
              oe_nxt   = 1'b1;
              st_nxt   = iep_pkg::SS_DACK;
            end
          end
        end
        iep_pkg::SS_TX: begin
          if (rise) cnt_nxt = cnt_r + 4'h1;
          if (fall) begin
            if (cnt_r < `IEP_ACK_BIT) begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = ~tx_r[6];
            end else begin
              oe_nxt = 1'b0;           // Free the wire for the master's answer.
              st_nxt = iep_pkg::SS_TACK;
            end
          end
        end
        iep_pkg::SS_TACK: begin
          if (rise) tack_nxt = ~sda_f_r;
          if (fall) begin
            if (tack_r) begin
              load_tx = 1'b1;
            end else begin
              st_nxt = iep_pkg::SS_IDLE;
            end
          end
        end
      endcase
    end
    // Fetch at the counter, then step it; the 8-bit sum wraps on its own.
    if (load_tx) begin
      tx_nxt  = mem_r[ptr_r];
      oe_nxt  = ~mem_r[ptr_r][7];
      ptr_nxt = ptr_r + 8'h1;
      cnt_nxt = 4'h0;
      st_nxt  = iep_pkg::SS_TX;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= iep_pkg::SS_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      tx_r   <= 8'h00;
      ptr_r  <= 8'h00;
      rw_r   <= 1'b0;
      oe_r   <= 1'b0;
      tack_r <= 1'b0;
      pend_r <= 1'b0;
      pa_r   <= 8'h00;
      pd_r   <= 8'h00;
      busy_r <= 24'h0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      tx_r   <= tx_nxt;
      ptr_r  <= ptr_nxt;
      rw_r   <= rw_nxt;
      oe_r   <= oe_nxt;
      tack_r <= tack_nxt;
      pend_r <= pend_nxt;
      pa_r   <= pa_nxt;
      pd_r   <= pd_nxt;
      busy_r <= busy_nxt;
    end
  end
  // **************************************************************
  // Memory array
  // **************************************************************
  // Only one pending byte is held, so a longer write keeps its last byte.
  always_comb begin
    mem_nxt = mem_r;
    if (commit) begin
      mem_nxt[pa_r] = pd_r;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `IEP_MEM_DEPTH; i++) begin
        mem_r[i] <= `IEP_ERASED;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end
  // The wire is open drain: only ever pull low.
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = oe_r;
  assign wr_busy      = (busy_r != 24'h0);
endmodule

// *** iep_chk.sv ***
// Concurrent checks on the two-wire link between the master and the EEPROM slave.
`timescale 1ns/1ns
module iep_chk #(
  parameter int unsigned TWR_CYC = 200
) (
  input logic mclk,
  input logic arst_n,
  input logic scl,
  input logic m_sda_o,
  input logic m_sda_oe,
  input logic s_sda_o,
  input logic s_sda_oe,
  input logic sda,
  input logic wp,
  input logic wr_busy
);
  int unsigned cnt_r;
  int unsigned cnt_nxt;

  // Length of the write cycle; a counter keeps the long span cheap to check.
  always_comb begin
    cnt_nxt = wr_busy ? cnt_r + 1 : 0;
  end

  // Registers the write cycle count.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // ************************************************************
  // Link assertions
  // ************************************************************
  a_sda_hold_high: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave data changed while clock high");
  a_ack_whole_bit: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("slave pulled data low too briefly");
  a_busy_silent: assert property (wr_busy |-> !s_sda_oe)
    else $error("slave drove data during write cycle");
  a_busy_at_stop: assert property ($rose(wr_busy) |-> scl && sda)
    else $error("write cycle began outside a stop");
  a_busy_length: assert property ($fell(wr_busy) |->
    (cnt_r + 1 >= TWR_CYC) && (cnt_r <= TWR_CYC + 1))
    else $error("write cycle length wrong");
  a_protect_no_prog: assert property ($rose(wr_busy) |-> !wp)
    else $error("write cycle under write protection");
  a_stop_release: assert property (scl && $rose(sda) |=> !s_sda_oe [*8])
    else $error("slave drove data after stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_open_drain: assert property (!m_sda_o && !s_sda_o)
    else $error("an end drove the data wire high");

  // Main scenarios reached.
  cover property ($rose(wr_busy));
  cover property ($fell(wr_busy));
  cover property (wp && $rose(s_sda_oe));
endmodule

// *** i2c_eeprom_read_poll_protect_bench.sv ***
// Self-checking bench joining the bus master and the EEPROM slave.
`timescale 1ns/1ns
module i2c_eeprom_read_poll_protect_bench;
  // Short write cycle, yet longer than one poll up to its acknowledge slot.
  localparam int unsigned TWR = 2500;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       wp = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_ready;
  logic [1:0] req_op = 2'h0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic [7:0] req_len = 8'h00;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       done;
  logic       done_nack;
  logic       wr_busy;
  logic [7:0] rd_q[$];
  int         err_total = 0;
  int         n_checks = 0;

  iep_if bus_if ();
  iep_master u_iep_master (.mclk(mclk), .arst_n(arst_n), .bus(bus_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_len(req_len),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .done_nack(done_nack));
  iep_slave #(.TWR_CYC(TWR)) u_iep_slave (.mclk(mclk), .arst_n(arst_n),
    .bus(bus_if), .wp(wp), .wr_busy(wr_busy));
  iep_chk #(.TWR_CYC(TWR)) u_iep_chk (.mclk(mclk), .arst_n(arst_n),
    .scl(bus_if.scl), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .sda(bus_if.sda),
    .wp(wp), .wr_busy(wr_busy));

  // Free-running clock at 125 MHz.
  always #4 mclk = ~mclk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask

  // One falling edge; a hung frame runs out the count and ends the run.
  task automatic tick(inout int n);
    @(negedge mclk);
    n++;
    if (n > 30000) begin
      err_total++;
      conclude();
    end
  endtask

  // One user request, held until the edge that takes it, then the whole frame.
  task automatic run(input iep_pkg::iep_op_t op, input logic [7:0] addr,
                     input logic [7:0] data, input logic [7:0] len);
    int n;
    n = 0;
    rd_q.delete();
    while (req_ready !== 1'b1) begin
      tick(n);
    end
    req_op = op;
    req_addr = addr;
    req_data = data;
    req_len = len;
    req_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    while (done !== 1'b1) begin
      if (rd_valid === 1'b1) begin
        rd_q.push_back(rd_data);
      end
      tick(n);
    end
  endtask

  // Byte write, then polls until the write cycle has ended.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    int k;
    run(iep_pkg::OP_WRITE, addr, data, 8'h01);
    chk_flag(done_nack, 1'b0);
    chk_flag(wr_busy, 1'b1);
    run(iep_pkg::OP_POLL, 8'h00, 8'h00, 8'h01);
    chk_flag(done_nack, 1'b1);
    k = 0;
    while (done_nack === 1'b1 && k < 6) begin
      run(iep_pkg::OP_POLL, 8'h00, 8'h00, 8'h01);
      k++;
    end
    chk_flag(done_nack, 1'b0);
  endtask

  // Read of len bytes compared with e, first byte in the top bits.
  task automatic rd_chk(input iep_pkg::iep_op_t op, input logic [7:0] addr,
                        input logic [7:0] len, input logic [31:0] e);
    run(op, addr, 8'h00, len);
    chk_flag(done_nack, 1'b0);
    chk_byte(8'(rd_q.size()), len);
    for (int j = 0; j < len; j++) begin
      chk_byte(rd_q[j], e[31-8*j -: 8]);
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(negedge mclk);
    chk_flag(bus_if.scl, 1'b1);
    chk_flag(bus_if.s_sda_oe, 1'b0);
    chk_flag(wr_busy, 1'b0);
    chk_flag(done_nack, 1'b0);
    chk_flag(req_ready, 1'b1);
    arst_n = 1'b1;
    @(negedge mclk);
    wr(8'h10, 8'hA5);
    wr(8'hFF, 8'h5A);
    wr(8'h00, 8'hC3);
    rd_chk(iep_pkg::OP_READ_RAND, 8'h0F, 8'h03, 32'hFFA5FF00);
    rd_chk(iep_pkg::OP_READ_RAND, 8'h0F, 8'h01, 32'hFF000000);
    rd_chk(iep_pkg::OP_READ_CUR, 8'h00, 8'h02, 32'hA5FF0000);
    rd_chk(iep_pkg::OP_READ_RAND, 8'hFE, 8'h03, 32'hFF5AC300);
    // Protected write: addresses accepted, data refused, nothing programmed.
    wp = 1'b1;
    run(iep_pkg::OP_WRITE, 8'h10, 8'h77, 8'h01);
    chk_flag(done_nack, 1'b1);
    chk_flag(wr_busy, 1'b0);
    wp = 1'b0;
    rd_chk(iep_pkg::OP_READ_RAND, 8'h10, 8'h01, 32'hA5000000);
    conclude();
  end
endmodule
